/* File: logic/i2ct_timing_gen.sv */
`timescale 1ns/1ps
`include "i2ct_consts.svh"

module i2ct_timing_gen #(
    parameter int BUS_KBPS = `I2CT_BUS_KBPS_DFLT
) (
    // system side
    input  wire logic       clock,
    input  wire logic       sys_rst,
    // command port
    input  wire logic       cmd_valid,
    input  wire logic [1:0] cmd_code,
    input  wire logic       cmd_bit,
    output logic            cmd_ready,
    output logic            cmd_done,
    output logic            rd_bit,
    output logic            arb_lost,
    // status and wake
    input  wire logic [6:0] own_addr,
    input  wire logic       wake_en,
    output logic            bus_busy,
    output logic            wake_req,
    // link side
    input  wire logic       link_clk,
    input  wire logic       scl_i,
    output logic            scl_o,
    output logic            scl_oe,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe
);

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    // rate range
    if (BUS_KBPS < 1 || BUS_KBPS > `I2CT_BUS_KBPS_MAX) begin : g_bad_rate
        $error("bus rate out of range");
    end

    // link clock is this many times the bit rate; only documents the expected rate
    localparam int LINK_KHZ = BUS_KBPS * `I2CT_OVERSAMPLE;

    i2ct_pkg::i2ct_sys_t  s_r;
    i2ct_pkg::i2ct_sys_t  s_nxt;
    i2ct_pkg::i2ct_link_t l_r;
    i2ct_pkg::i2ct_link_t l_nxt;
    logic                 lrst_s1_r;
    logic                 lrst_s2_r;

    // ----------------------------------------------------------------
    // system domain: command handshake and status capture
    // ----------------------------------------------------------------
    always_comb begin
        s_nxt          = s_r;
        s_nxt.done     = 1'b0;
        s_nxt.wake_req = 1'b0;
        s_nxt.ack_s1   = l_r.ack_tgl;
        s_nxt.ack_s2   = s_r.ack_s1;
        s_nxt.ack_s3   = s_r.ack_s2;
        s_nxt.busy_s1  = l_r.busy;
        s_nxt.busy_s2  = s_r.busy_s1;
        s_nxt.wake_s1  = l_r.wake_tgl;
        s_nxt.wake_s2  = s_r.wake_s1;
        s_nxt.wake_s3  = s_r.wake_s2;
        if (cmd_valid && s_r.ready) begin
            s_nxt.ready   = 1'b0;
            s_nxt.cmd     = i2ct_pkg::i2ct_cmd_t'(cmd_code);
            s_nxt.bit_tx  = cmd_bit;
            s_nxt.req_tgl = ~s_r.req_tgl;
        end
        // result words are stable in the link domain by the cycle in which the ack toggles
        if (s_r.ack_s2 != s_r.ack_s3) begin
            s_nxt.ready    = 1'b1;
            s_nxt.done     = 1'b1;
            s_nxt.rd_bit   = l_r.rd;
            s_nxt.arb_lost = l_r.arb;
        end
        if (s_r.wake_s2 != s_r.wake_s3) begin
            s_nxt.wake_req = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            s_r       <= '0;
            s_r.ready <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign cmd_ready = s_r.ready;
    assign cmd_done  = s_r.done;
    assign rd_bit    = s_r.rd_bit;
    assign arb_lost  = s_r.arb_lost;
    assign bus_busy  = s_r.busy_s2;
    assign wake_req  = s_r.wake_req;

    // ----------------------------------------------------------------
    // link domain reset
    // ----------------------------------------------------------------
    // a pulse shorter than one link cycle may miss the link domain
    always_ff @(posedge link_clk) begin
        lrst_s1_r <= sys_rst;
        lrst_s2_r <= lrst_s1_r;
    end

    // ----------------------------------------------------------------
    // link domain: pin sampling, bus monitor, master sequencer
    // ----------------------------------------------------------------
    logic scl_in;
    logic sda_in;
    logic new_req;
    logic scl_rise;
    logic start_det;
    logic stop_det;
    logic bus_free;

    assign scl_in   = l_r.scl_s2;
    assign sda_in   = l_r.sda_s2;
    assign new_req  = l_r.req_s2 ^ l_r.req_s3;
    assign scl_rise = scl_in && !l_r.scl_p;
    // a start or stop only counts if scl is still high one sample later
    assign start_det = l_r.st_cand && scl_in && !sda_in;
    assign stop_det  = l_r.sp_cand && scl_in && sda_in;
    // free only after the full idle interval
    assign bus_free  = !l_r.busy && (l_r.free_cnt == `I2CT_T_BUF_CYC);

    always_comb begin
        l_nxt        = l_r;
        l_nxt.req_s1 = s_r.req_tgl;
        l_nxt.req_s2 = l_r.req_s1;
        l_nxt.req_s3 = l_r.req_s2;
        l_nxt.scl_s1 = scl_i;
        l_nxt.scl_s2 = l_r.scl_s1;
        l_nxt.sda_s1 = sda_i;
        l_nxt.sda_s2 = l_r.sda_s1;
        l_nxt.scl_p  = scl_in;
        l_nxt.sda_p  = sda_in;
        l_nxt.addr_s1 = own_addr;
        l_nxt.addr_s2 = l_r.addr_s1;
        l_nxt.wen_s1  = wake_en;
        l_nxt.wen_s2  = l_r.wen_s1;

        // count stable high samples of scl
        if (!scl_in) begin
            l_nxt.hi_cnt = `I2CT_CNT_RST;
        end else if (l_r.hi_cnt != `I2CT_START_FILT_CYC) begin
            l_nxt.hi_cnt = l_r.hi_cnt + 6'h01;
        end
        l_nxt.st_cand = l_r.scl_p && scl_in && l_r.sda_p && !sda_in
                        && (l_r.hi_cnt == `I2CT_START_FILT_CYC);
        l_nxt.sp_cand = l_r.scl_p && scl_in && !l_r.sda_p && sda_in;

        if (start_det) begin
            l_nxt.busy = 1'b1;
        end else if (stop_det) begin
            l_nxt.busy = 1'b0;
        end
        if (start_det || stop_det || l_r.busy || !scl_in || !sda_in) begin
            l_nxt.free_cnt = `I2CT_CNT_RST;
        end else if (!bus_free) begin
            l_nxt.free_cnt = l_r.free_cnt + 6'h01;
        end

        // address capture; the slave path never touches scl_oe
        if (start_det) begin
            l_nxt.in_addr = 1'b1;
            l_nxt.bcnt    = 4'h0;
        end else if (stop_det) begin
            l_nxt.in_addr = 1'b0;
        end else if (l_r.in_addr && scl_rise) begin
            l_nxt.shift = {l_r.shift[5:0], sda_in};
            l_nxt.bcnt  = l_r.bcnt + 4'h1;
            if (l_r.bcnt == `I2CT_BITCNT_LAST) begin
                l_nxt.in_addr = 1'b0;
                if (l_r.wen_s2 && ({l_r.shift[5:0], sda_in} == l_r.addr_s2)) begin
                    l_nxt.wake_tgl = ~l_r.wake_tgl;
                end
            end
        end

        // master sequencer
        l_nxt.cnt = l_r.cnt + 6'h01;
        unique case (l_r.st)
            i2ct_pkg::I2CT_IDLE: begin
                l_nxt.scl_oe = 1'b0;
                l_nxt.sda_oe = 1'b0;
                l_nxt.cnt    = `I2CT_CNT_RST;
                if (new_req) begin
                    l_nxt.arb = 1'b0;
                    if (s_r.cmd != i2ct_pkg::I2CT_CMD_START) begin
                        l_nxt.req_s3  = l_r.req_s2;
                        l_nxt.ack_tgl = ~l_r.ack_tgl;
                    end else if (bus_free) begin
                        // start only on a free bus
                        l_nxt.st = i2ct_pkg::I2CT_START_SU;
                    end else begin
                        // hold the request until the bus is free
                        l_nxt.req_s3 = l_r.req_s3;
                    end
                end
            end
            i2ct_pkg::I2CT_START_SU: begin
                if (!sda_in) begin
                    l_nxt.arb     = 1'b1;
                    l_nxt.ack_tgl = ~l_r.ack_tgl;
                    l_nxt.st      = i2ct_pkg::I2CT_IDLE;
                end else if (l_r.cnt == `I2CT_T_SU_STA_CYC - 6'h01) begin
                    // scl high for setup, then sda falls
                    l_nxt.sda_oe = 1'b1;
                    l_nxt.cnt    = `I2CT_CNT_RST;
                    l_nxt.st     = i2ct_pkg::I2CT_START_HD;
                end
            end
            i2ct_pkg::I2CT_START_HD: begin
                // hold scl high after sda falls, then first clock low
                if (l_r.cnt == `I2CT_T_HD_STA_CYC - 6'h01) begin
                    l_nxt.scl_oe  = 1'b1;
                    l_nxt.ack_tgl = ~l_r.ack_tgl;
                    l_nxt.st      = i2ct_pkg::I2CT_WAIT;
                end
            end
            i2ct_pkg::I2CT_WAIT: begin
                l_nxt.cnt = `I2CT_CNT_RST;
                if (new_req) begin
                    l_nxt.arb = 1'b0;
                    unique case (s_r.cmd)
                        i2ct_pkg::I2CT_CMD_START: begin
                            // sda released a cycle or more after scl fell
                            l_nxt.sda_oe = 1'b0;
                            l_nxt.st     = i2ct_pkg::I2CT_RS_LOW;
                        end
                        i2ct_pkg::I2CT_CMD_STOP: begin
                            l_nxt.sda_oe = 1'b1;
                            l_nxt.st     = i2ct_pkg::I2CT_STOP_LOW;
                        end
                        i2ct_pkg::I2CT_CMD_WRITE: begin
                            // a one bit releases sda, a zero pulls low
                            l_nxt.bit_tx  = s_r.bit_tx;
                            l_nxt.is_read = 1'b0;
                            l_nxt.sda_oe  = ~s_r.bit_tx;
                            l_nxt.st      = i2ct_pkg::I2CT_LOW;
                        end
                        i2ct_pkg::I2CT_CMD_READ: begin
                            l_nxt.bit_tx  = 1'b1;
                            l_nxt.is_read = 1'b1;
                            l_nxt.sda_oe  = 1'b0;
                            l_nxt.st      = i2ct_pkg::I2CT_LOW;
                        end
                    endcase
                end
            end
            i2ct_pkg::I2CT_LOW: begin
                // eight cycles low, data settled well before the rise
                if (l_r.cnt == `I2CT_T_LOW_CYC - 6'h01) begin
                    l_nxt.scl_oe = 1'b0;
                    l_nxt.cnt    = `I2CT_CNT_RST;
                    l_nxt.st     = i2ct_pkg::I2CT_HIGH;
                end
            end
            i2ct_pkg::I2CT_HIGH: begin
                // a stretching slave lengthens high, so the rate can drift
                if (!scl_in) begin
                    l_nxt.cnt = l_r.cnt;
                end else begin
                    if (l_r.cnt == `I2CT_T_SAMPLE_CYC) begin
                        l_nxt.rd = sda_in;
                    end
                    if (l_r.bit_tx && !l_r.is_read && !sda_in) begin
                        l_nxt.arb     = 1'b1;
                        l_nxt.sda_oe  = 1'b0;
                        l_nxt.ack_tgl = ~l_r.ack_tgl;
                        l_nxt.st      = i2ct_pkg::I2CT_IDLE;
                    end else if (l_r.cnt == `I2CT_T_HIGH_CYC - 6'h01) begin
                        // ten cycles high: eight counted samples after the two-cycle scl sync
                        l_nxt.scl_oe  = 1'b1;
                        l_nxt.ack_tgl = ~l_r.ack_tgl;
                        l_nxt.st      = i2ct_pkg::I2CT_WAIT;
                    end
                end
            end
            i2ct_pkg::I2CT_STOP_LOW: begin
                if (l_r.cnt == `I2CT_T_LOW_CYC - 6'h01) begin
                    l_nxt.scl_oe = 1'b0;
                    l_nxt.cnt    = `I2CT_CNT_RST;
                    l_nxt.st     = i2ct_pkg::I2CT_STOP_SU;
                end
            end
            i2ct_pkg::I2CT_STOP_SU: begin
                // count only while scl really reads high
                if (!scl_in) begin
                    l_nxt.cnt = `I2CT_CNT_RST;
                end else if (l_r.cnt == `I2CT_T_SU_STO_CYC - 6'h01) begin
                    l_nxt.sda_oe  = 1'b0;
                    l_nxt.ack_tgl = ~l_r.ack_tgl;
                    l_nxt.st      = i2ct_pkg::I2CT_IDLE;
                end
            end
            i2ct_pkg::I2CT_RS_LOW: begin
                if (l_r.cnt == `I2CT_T_LOW_CYC - 6'h01) begin
                    l_nxt.scl_oe = 1'b0;
                    l_nxt.cnt    = `I2CT_CNT_RST;
                    l_nxt.st     = i2ct_pkg::I2CT_RS_SU;
                end
            end
            i2ct_pkg::I2CT_RS_SU: begin
                // repeated start setup with scl seen high
                if (!scl_in) begin
                    l_nxt.cnt = `I2CT_CNT_RST;
                end else if (l_r.cnt == `I2CT_T_SU_STA_CYC - 6'h01) begin
                    l_nxt.sda_oe = 1'b1;
                    l_nxt.cnt    = `I2CT_CNT_RST;
                    l_nxt.st     = i2ct_pkg::I2CT_START_HD;
                end
            end
            default: begin
                l_nxt.scl_oe = 1'b0;
                l_nxt.sda_oe = 1'b0;
                l_nxt.st     = i2ct_pkg::I2CT_IDLE;
            end
        endcase
    end

    always_ff @(posedge link_clk) begin
        if (lrst_s2_r) begin
            l_r        <= '0;
            l_r.scl_s1 <= 1'b1;
            l_r.scl_s2 <= 1'b1;
            l_r.sda_s1 <= 1'b1;
            l_r.sda_s2 <= 1'b1;
            l_r.scl_p  <= 1'b1;
            l_r.sda_p  <= 1'b1;
        end else begin
            l_r <= l_nxt;
        end
    end

    // open drain: the driven level is always low
    assign scl_o  = 1'b0;
    assign sda_o  = 1'b0;
    assign scl_oe = l_r.scl_oe;
    assign sda_oe = l_r.sda_oe;

endmodule

/* File: logic/i2ct_consts.svh */
`ifndef I2CT_CONSTS_SVH
`define I2CT_CONSTS_SVH

// ----------------------------------------------------------------
// bus rate and oversampling
// ----------------------------------------------------------------
`define I2CT_BUS_KBPS_DFLT   100
`define I2CT_BUS_KBPS_MAX    1000
`define I2CT_OVERSAMPLE      16

// ----------------------------------------------------------------
// bus timing, in link clock cycles
// ----------------------------------------------------------------
`define I2CT_T_LOW_CYC       6'h08
`define I2CT_T_HIGH_CYC      6'h08
`define I2CT_T_HD_STA_CYC    6'h0f
`define I2CT_T_SU_STA_CYC    6'h09
`define I2CT_T_HD_DAT_CYC    6'h01
`define I2CT_T_SU_DAT_CYC    6'h07
`define I2CT_T_SU_STO_CYC    6'h09
`define I2CT_T_BUF_CYC       6'h20
`define I2CT_T_SAMPLE_CYC    6'h03
`define I2CT_START_FILT_CYC  6'h02

// ----------------------------------------------------------------
// reset values and field layout
// ----------------------------------------------------------------
`define I2CT_ADDR_W          7
`define I2CT_ADDR_RST        7'h00
`define I2CT_CNT_RST         6'h00
`define I2CT_BITCNT_LAST     4'h6

`endif

/* File: logic/i2ct_pkg.sv */
package i2ct_pkg;

    typedef enum logic [1:0] {
        I2CT_CMD_START = 2'h0,
        I2CT_CMD_WRITE = 2'h1,
        I2CT_CMD_READ  = 2'h2,
        I2CT_CMD_STOP  = 2'h3
    } i2ct_cmd_t;

    // gray along idle -> start -> bits -> stop
    typedef enum logic [3:0] {
        I2CT_IDLE     = 4'h0,
        I2CT_START_SU = 4'h1,
        I2CT_START_HD = 4'h3,
        I2CT_WAIT     = 4'h2,
        I2CT_LOW      = 4'h6,
        I2CT_HIGH     = 4'h7,
        I2CT_STOP_LOW = 4'h5,
        I2CT_STOP_SU  = 4'h4,
        I2CT_RS_LOW   = 4'hd,
        I2CT_RS_SU    = 4'hf
    } i2ct_state_t;

    typedef struct packed {
        logic        ready;
        logic        req_tgl;
        i2ct_cmd_t   cmd;
        logic        bit_tx;
        logic        ack_s1;
        logic        ack_s2;
        logic        ack_s3;
        logic        done;
        logic        rd_bit;
        logic        arb_lost;
        logic        busy_s1;
        logic        busy_s2;
        logic        wake_s1;
        logic        wake_s2;
        logic        wake_s3;
        logic        wake_req;
    } i2ct_sys_t;

    typedef struct packed {
        logic        req_s1;
        logic        req_s2;
        logic        req_s3;
        i2ct_state_t st;
        logic [5:0]  cnt;
        logic        scl_oe;
        logic        sda_oe;
        logic        bit_tx;
        logic        is_read;
        logic        rd;
        logic        arb;
        logic        ack_tgl;
        logic        scl_s1;
        logic        scl_s2;
        logic        sda_s1;
        logic        sda_s2;
        logic        scl_p;
        logic        sda_p;
        logic [5:0]  hi_cnt;
        logic        st_cand;
        logic        sp_cand;
        logic        busy;
        logic [5:0]  free_cnt;
        logic [6:0]  addr_s1;
        logic [6:0]  addr_s2;
        logic        wen_s1;
        logic        wen_s2;
        logic [6:0]  shift;
        logic [3:0]  bcnt;
        logic        in_addr;
        logic        wake_tgl;
    } i2ct_link_t;

endpackage

/* File: tb/i2ct_chk.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------
// link timing checker
// ----------------------------------------------------------------
module i2ct_chk (
    // clock and reset
    input wire logic link_clk,
    input wire logic sys_rst,
    // bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic scl_o,
    input wire logic sda_o,
    input wire logic scl_oe,
    input wire logic sda_oe
);
    logic [5:0] hi_run_r;
    logic [5:0] free_run_r;
    logic [5:0] sda_age_r;
    logic       sda_last_r;
    logic       sda_q_r;
    logic       stop_last_r;

    default clocking cb @(posedge link_clk);
    endclocking
    default disable iff (sys_rst);

    // raw bus counts lead the design's synchronised view, so minima stay safe
    always_ff @(posedge link_clk) begin
        if (sys_rst) begin
            hi_run_r    <= 6'h00;
            free_run_r  <= 6'h00;
            sda_age_r   <= 6'h00;
            sda_last_r  <= 1'b0;
            sda_q_r     <= 1'b1;
            stop_last_r <= 1'b1;
        end else begin
            hi_run_r    <= scl_i ? hi_run_r + 6'(hi_run_r != 6'h3f) : 6'h00;
            free_run_r  <= (scl_i && sda_i) ? free_run_r + 6'(free_run_r != 6'h3f) : 6'h00;
            sda_age_r   <= (sda_oe != sda_last_r) ? 6'h00 : sda_age_r + 6'(sda_age_r != 6'h3f);
            sda_last_r  <= sda_oe;
            sda_q_r     <= sda_i;
            // a rising data line with the clock high marks a stop
            if (sda_i && !sda_q_r)
                stop_last_r <= scl_i;
        end
    end

    property p_low_len;
        $rose(scl_oe) |-> scl_oe[*8];
    endproperty
    a_low_len: assert property (p_low_len) else $error("scl low phase short");
    property p_high_len;
        $fell(scl_oe) |-> !scl_oe[*8];
    endproperty
    a_high_len: assert property (p_high_len) else $error("scl high phase short");
    property p_start_hold;
        $rose(sda_oe) && !scl_oe |-> !scl_oe[*8] ##1 !scl_oe[*7] ##[1:2] scl_oe;
    endproperty
    a_start_hold: assert property (p_start_hold) else $error("start hold wrong");
    property p_start_setup;
        $rose(sda_oe) && !scl_oe |-> hi_run_r >= 6'd9;
    endproperty
    a_start_setup: assert property (p_start_setup) else $error("start setup short");
    property p_stop_setup;
        $fell(sda_oe) && !scl_oe && scl_i |-> hi_run_r >= 6'd9;
    endproperty
    a_stop_setup: assert property (p_stop_setup) else $error("stop setup short");
    property p_bus_free;
        $rose(sda_oe) && !scl_oe && stop_last_r |-> free_run_r >= 6'd32;
    endproperty
    a_bus_free: assert property (p_bus_free) else $error("start inside bus free");
    property p_data_hold;
        $rose(scl_oe) |-> $stable(sda_oe) ##1 $stable(sda_oe);
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("sda moved with scl");
    // the age lags one edge: five means six cycles of setup
    property p_data_setup;
        $fell(scl_oe) |-> sda_age_r >= 6'd5;
    endproperty
    a_data_setup: assert property (p_data_setup) else $error("data setup short");
    property p_pull_only;
        !scl_o && !sda_o;
    endproperty
    a_pull_only: assert property (p_pull_only) else $error("pin driven high");
endmodule

bind i2ct_timing_gen i2ct_chk i2ct_chk_inst (
    .link_clk(link_clk), .sys_rst(sys_rst), .scl_i(scl_i), .sda_i(sda_i),
    .scl_o(scl_o), .sda_o(sda_o), .scl_oe(scl_oe), .sda_oe(sda_oe)
);

/* File: tb/i2ct_bus_model.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------
// far side: pull-ups, a slow slave and a second master
// ----------------------------------------------------------------
module i2ct_bus_model (
    // link clock
    input wire logic link_clk,
    // design pulls
    input wire logic scl_oe,
    input wire logic sda_oe,
    // resolved lines
    output logic     scl,
    output logic     sda
);
    logic m_scl_low = 1'b0;
    logic m_sda_low = 1'b0;
    logic ack_low   = 1'b0;
    logic held      = 1'b0;
    int   stretch   = 0;

    assign scl = !(scl_oe | m_scl_low);
    assign sda = !(sda_oe | m_sda_low | ack_low);

    // slow slave keeps the clock low after each fall
    always @(negedge scl) begin
        if (stretch > 0) begin
            m_scl_low <= 1'b1;
            repeat (stretch) @(posedge link_clk);
            m_scl_low <= 1'b0;
        end
    end

    task automatic master_addr(input logic [7:0] b);
        repeat (40) @(posedge link_clk);
        m_sda_low <= 1'b1;
        repeat (15) @(posedge link_clk);
        for (int i = 7; i >= 0; i--) begin
            // data moves on the very edge that drops the clock
            m_scl_low <= 1'b1;
            m_sda_low <= !b[i];
            repeat (8) @(posedge link_clk);
            m_scl_low <= 1'b0;
            repeat (2) @(posedge link_clk);
            if (!scl)
                held <= 1'b1;
            repeat (6) @(posedge link_clk);
        end
        m_scl_low <= 1'b1;
        m_sda_low <= 1'b1;
        repeat (8) @(posedge link_clk);
        m_scl_low <= 1'b0;
        repeat (9) @(posedge link_clk);
        m_sda_low <= 1'b0;
        repeat (32) @(posedge link_clk);
    endtask
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ps

module tb;
    // ----------------------------------------------------------------
    // stimulus, pins and tallies
    // ----------------------------------------------------------------
    logic       clock     = 1'b0;
    logic       link_clk  = 1'b0;
    logic       sys_rst   = 1'b1;
    logic       cmd_valid = 1'b0;
    logic [1:0] cmd_code  = 2'h0;
    logic       cmd_bit   = 1'b0;
    logic [6:0] own_addr  = 7'h1e;
    logic       wake_en   = 1'b0;
    logic       cmd_ready, cmd_done, rd_bit, arb_lost, bus_busy, wake_req;
    logic       scl_oe, sda_oe, scl, sda;
    logic [7:0] seen      = 8'h00;
    int         bad_count = 0;
    int         compares  = 0;
    int         wakes     = 0;

    initial begin
        forever #4 clock = ~clock;
    end
    initial begin
        #7;
        forever #15 link_clk = ~link_clk;
    end

    i2ct_timing_gen i2ct_timing_gen_inst (
        .clock(clock), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_bit(cmd_bit), .cmd_ready(cmd_ready), .cmd_done(cmd_done), .rd_bit(rd_bit),
        .arb_lost(arb_lost), .own_addr(own_addr), .wake_en(wake_en), .bus_busy(bus_busy),
        .wake_req(wake_req), .link_clk(link_clk), .scl_i(scl), .scl_o(), .scl_oe(scl_oe),
        .sda_i(sda), .sda_o(), .sda_oe(sda_oe)
    );
    i2ct_bus_model i2ct_bus_model_inst (
        .link_clk(link_clk), .scl_oe(scl_oe), .sda_oe(sda_oe), .scl(scl), .sda(sda)
    );

    always @(posedge scl) seen <= {seen[6:0], sda};
    always @(posedge clock) if (wake_req === 1'b1) wakes <= wakes + 1;

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic do_cmd(input logic [1:0] code, input logic b);
        int n;
        n = 0;
        @(negedge clock);
        cmd_valid = 1'b1;
        cmd_code  = code;
        cmd_bit   = b;
        @(negedge clock);
        cmd_valid = 1'b0;
        while (cmd_done !== 1'b1 && n < 4000) begin
            @(negedge clock);
            n++;
        end
        check("command done", 8'h01, {7'h00, cmd_done});
    endtask

    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            do_cmd(i2ct_pkg::I2CT_CMD_WRITE, b[i]);
            check("write arbitration", 8'h00, {7'h00, arb_lost});
        end
    endtask

    // far side keeps its bit one link cycle past the clock fall
    task automatic set_ack(input logic v);
        @(posedge link_clk);
        i2ct_bus_model_inst.ack_low <= v;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        check("ready after reset", 8'h01, {7'h00, cmd_ready});
        check("outputs after reset", 8'h00,
              {1'b0, cmd_done, rd_bit, arb_lost, bus_busy, wake_req, scl_oe, sda_oe});
    endtask

    task automatic t_transfer();
        do_cmd(i2ct_pkg::I2CT_CMD_START, 1'b0);
        check("busy after start", 8'h01, {7'h00, bus_busy});
        send_byte(8'ha5);
        check("bus byte", 8'ha5, seen);
        set_ack(1'b1);
        do_cmd(i2ct_pkg::I2CT_CMD_READ, 1'b1);
        check("ack bit", 8'h00, {7'h00, rd_bit});
        set_ack(1'b0);
        do_cmd(i2ct_pkg::I2CT_CMD_READ, 1'b1);
        check("read bit", 8'h01, {7'h00, rd_bit});
        do_cmd(i2ct_pkg::I2CT_CMD_START, 1'b0);
        send_byte(8'h5a);
        check("byte after restart", 8'h5a, seen);
        do_cmd(i2ct_pkg::I2CT_CMD_STOP, 1'b0);
        do_cmd(i2ct_pkg::I2CT_CMD_START, 1'b0);
        do_cmd(i2ct_pkg::I2CT_CMD_STOP, 1'b0);
    endtask

    task automatic t_stretch();
        i2ct_bus_model_inst.stretch = 20;
        do_cmd(i2ct_pkg::I2CT_CMD_START, 1'b0);
        send_byte(8'hc3);
        check("stretched byte", 8'hc3, seen);
        do_cmd(i2ct_pkg::I2CT_CMD_STOP, 1'b0);
        i2ct_bus_model_inst.stretch = 0;
    endtask

    task automatic t_arb();
        do_cmd(i2ct_pkg::I2CT_CMD_START, 1'b0);
        set_ack(1'b1);
        do_cmd(i2ct_pkg::I2CT_CMD_WRITE, 1'b1);
        check("lost arbitration", 8'h01, {7'h00, arb_lost});
        check("pins let go", 8'h00, {6'h00, scl_oe, sda_oe});
        set_ack(1'b0);
    endtask

    // match, other address, match with wake off
    task automatic t_wake();
        int n0;
        for (int i = 0; i < 3; i++) begin
            @(negedge clock);
            own_addr = (i == 1) ? 7'h1f : 7'h1e;
            wake_en  = (i != 2);
            n0       = wakes;
            i2ct_bus_model_inst.master_addr(8'h3c);
            check("wake count", {7'h00, i == 0}, 8'(wakes - n0));
            check("slave holds clock", 8'h00, {7'h00, i2ct_bus_model_inst.held});
            check("busy after stop", 8'h00, {7'h00, bus_busy});
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // long reset: spans over four link cycles so the link side sees it
    initial begin
        repeat (16) @(posedge clock);
        @(negedge clock);
        sys_rst = 1'b0;
        repeat (12) @(negedge clock);
        t_reset();
        t_transfer();
        t_stretch();
        t_arb();
        t_wake();
        print_verdict();
    end

    initial begin
        #400000;
        bad_count++;
        $display("[FAIL] watchdog expected finish seen hang");
        print_verdict();
    end
endmodule
